// File: design/adcsq_defs.vh
`ifndef ADCSQ_DEFS_VH
`define ADCSQ_DEFS_VH
// register indices (printed offsets are not multiples of four)
`define ADCSQ_IDX_CSR 8'h70
`define ADCSQ_IDX_DRH 8'h71
`define ADCSQ_IDX_DRL 8'h72
`define ADCSQ_IDX_HALT 8'h73
// control field positions
`define ADCSQ_EOC_BIT 7
`define ADCSQ_SPEED_BIT 6
`define ADCSQ_ON_BIT 5
`define ADCSQ_RSV_BIT 4
`define ADCSQ_CH_HI 3
`define ADCSQ_CH_LO 0
`define ADCSQ_CSR_RST 8'h00
`define ADCSQ_RES_RST 10'h000
// converter clock dividers, in cpu clocks minus one
`define ADCSQ_DIV4_M1 2'h3
`define ADCSQ_DIV2_M1 2'h1
// converter clocks per conversion: sample plus ten bit decisions
`define ADCSQ_SAMPLE_CLKS 4'h2
`define ADCSQ_NBITS 4'hA
`define ADCSQ_FULL 10'h3FF
`define ADCSQ_RESP_OKAY 2'h0
`define ADCSQ_RESP_SLVERR 2'h2
`endif

// File: design/adcsq_sar.v
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_defs.vh"
// ----------------------------------------
// successive approximation engine
// ----------------------------------------
module adcsq_sar (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // control
  input wire run,
  input wire restart,
  input wire speed,
  // analog comparator
  output reg [9:0] dac_code,
  input wire cmp_above,
  output reg sample_hold,
  // result
  output reg done,
  output reg [9:0] result
);
  reg [1:0] div_r;
  reg [3:0] step_r;
  reg [9:0] trial_r;
  wire tick;
  wire [1:0] div_top;
  assign div_top = speed ? `ADCSQ_DIV2_M1 : `ADCSQ_DIV4_M1;
  assign tick = (div_r == div_top);
  always @(posedge aclk) begin
    if (!aresetn || !run || restart) begin
      div_r <= 2'h0;
      step_r <= 4'h0;
      trial_r <= 10'h000;
      dac_code <= 10'h000;
      sample_hold <= 1'b0;
      done <= 1'b0;
      result <= `ADCSQ_RES_RST;
    end else begin
      done <= 1'b0;
      if (tick) div_r <= 2'h0;
      else div_r <= div_r + 2'h1;
      if (tick) begin
        if (step_r < `ADCSQ_SAMPLE_CLKS) begin
          sample_hold <= 1'b1;
          trial_r <= 10'h200;
          dac_code <= 10'h200;
          step_r <= step_r + 4'h1;
        end else begin
          sample_hold <= 1'b0;
          // keep the trial bit only if input is above the trial level
          if (!cmp_above) trial_r <= trial_r & ~(trial_r ^ (trial_r & ~(trial_r - 10'h001)));
          if (step_r == `ADCSQ_SAMPLE_CLKS + `ADCSQ_NBITS - 4'h1) begin
            result <= cmp_above ? trial_r : (trial_r & (trial_r - 10'h001)) | (trial_r & ~(trial_r ^ (trial_r - 10'h001)) & 10'h000) | (trial_r & ~(trial_r & ~(trial_r - 10'h001)));
            done <= 1'b1;
            step_r <= 4'h0;
          end else begin
            step_r <= step_r + 4'h1;
            trial_r <= (cmp_above ? trial_r : (trial_r & ~(trial_r & ~(trial_r - 10'h001)))) | ((trial_r & ~(trial_r - 10'h001)) >> 1);
            dac_code <= (cmp_above ? trial_r : (trial_r & ~(trial_r & ~(trial_r - 10'h001)))) | ((trial_r & ~(trial_r - 10'h001)) >> 1);
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: design/adcsq_top.v
// Functional notes
// - input above high reference yields 3FF, high byte FF, low 03, no overflow.
// - input below low reference yields zero in both result registers.
// - binary search against comparator gives monotonic codes.
// - four bit input_select drives the analog mux as a binary index.
// - converter_on set starts continuous back-to-back conversions.
// - converter_on clear stops conversion and powers converter down.
// - each finished conversion stores result and sets end-of-conversion flag.
// - flag clears on high result read and on any control write with byte lane 0 strobed.
// - results are overwritten by every conversion, never latched.
// - changing input_select aborts, clears flag, restarts on new channel.
// - speed bit zero divides cpu clock by four, one by two.
// - high byte holds bits 9:2; low byte bits 1:0, rest zero.
// - wait mode leaves converter running; halt mode disables it.
// - reset clears control and both result registers.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_defs.vh"
module adcsq_top (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // analog front end
  output reg [3:0] input_select,
  output reg converter_on,
  output wire [9:0] dac_code,
  output wire sample_hold,
  input wire cmp_above,
  // power mode
  input wire halt_mode
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg eoc_r;
  reg speed_r;
  reg [9:0] result_r;
  reg [31:0] awaddr_r;
  reg aw_full_r;
  reg [31:0] wdata_r;
  reg wstrb0_r;
  reg w_full_r;
  wire [9:0] sar_result;
  wire sar_done;
  wire run;
  wire restart;
  wire [7:0] csr_val;
  wire do_write;
  wire do_read;
  wire [7:0] widx;
  wire [7:0] ridx;
  wire w_csr;
  wire r_drh;
  wire [7:0] wbyte;
  assign run = converter_on && !halt_mode;
  assign csr_val = {eoc_r, speed_r, converter_on, 1'b0, input_select};
  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
  assign s_axi_wready = !w_full_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_full_r && w_full_r && !s_axi_bvalid;
  assign do_read = s_axi_arvalid && !s_axi_rvalid;
  assign widx = awaddr_r[9:2];
  assign ridx = s_axi_araddr[9:2];
  assign wbyte = wdata_r[7:0];
  assign w_csr = do_write && wstrb0_r && awaddr_r[31:10] == 22'h000000
    && widx == `ADCSQ_IDX_CSR;
  assign r_drh = do_read && s_axi_araddr[31:10] == 22'h000000
    && ridx == `ADCSQ_IDX_DRH;
  assign restart = w_csr
    && wbyte[`ADCSQ_CH_HI:`ADCSQ_CH_LO] != input_select;
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= 32'h00000000;
      wdata_r <= 32'h00000000;
      wstrb0_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ADCSQ_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `ADCSQ_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_r[31:10] == 22'h000000 && (widx == `ADCSQ_IDX_CSR
            || widx == `ADCSQ_IDX_DRH || widx == `ADCSQ_IDX_DRL))
          s_axi_bresp <= `ADCSQ_RESP_OKAY;
        else
          s_axi_bresp <= `ADCSQ_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `ADCSQ_RESP_OKAY;
        s_axi_rdata <= 32'h00000000;
        if (s_axi_araddr[31:10] != 22'h000000)
          s_axi_rresp <= `ADCSQ_RESP_SLVERR;
        else if (ridx == `ADCSQ_IDX_CSR)
          s_axi_rdata <= {24'h000000, csr_val};
        else if (ridx == `ADCSQ_IDX_DRH)
          s_axi_rdata <= {24'h000000, result_r[9:2]};
        else if (ridx == `ADCSQ_IDX_DRL)
          s_axi_rdata <= {30'h00000000, result_r[1:0]};
        else
          s_axi_rresp <= `ADCSQ_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // control, status and result
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      eoc_r <= 1'b0;
      speed_r <= 1'b0;
      converter_on <= 1'b0;
      input_select <= 4'h0;
      result_r <= `ADCSQ_RES_RST;
    end else begin
      if (w_csr) begin
        speed_r <= wbyte[`ADCSQ_SPEED_BIT];
        converter_on <= wbyte[`ADCSQ_ON_BIT];
        input_select <= wbyte[`ADCSQ_CH_HI:`ADCSQ_CH_LO];
      end
      // set wins over a clear in the same cycle, except on restart
      if (sar_done && run && !restart) begin
        result_r <= sar_result;
        eoc_r <= 1'b1;
      end else if (w_csr || r_drh) begin
        eoc_r <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // converter engine
  // ----------------------------------------
  adcsq_sar u_sar (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run),
    .restart(restart),
    .speed(speed_r),
    .dac_code(dac_code),
    .cmp_above(cmp_above),
    .sample_hold(sample_hold),
    .done(sar_done),
    .result(sar_result)
  );
endmodule
`default_nettype wire

// File: testbench/adcsq_afe.sv
`timescale 1ns/1ps
`default_nettype none
module adcsq_afe (
  // mux and comparator
  input wire logic [3:0] input_select,
  input wire logic converter_on,
  input wire logic [9:0] dac_code,
  output logic cmp_above
);
  // analog level per channel in code units; beyond 0..1023 is out of range
  int lvl [16];
  // powered down: comparator output wanders with the trial code
  assign cmp_above = converter_on ? (lvl[input_select] >= int'(dac_code))
                                  : ^dac_code;
endmodule
`default_nettype wire

// File: testbench/adcsq_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module adcsq_chk (
  // clock, reset, read channel
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  // converter side
  input wire [3:0] input_select,
  input wire converter_on,
  input wire sample_hold,
  input wire halt_mode
);
  reg [31:0] ar_r;
  always @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) ar_r <= s_axi_araddr;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_clear: assert property ($rose(aresetn) |->
    !converter_on && input_select == 4'h0) else $error("reset not clear");
  a_start_sample: assert property ($rose(converter_on) |->
    ##[0:8] sample_hold) else $error("no sampling after enable");
  a_repeat_conv: assert property ($fell(sample_hold) && converter_on |->
    ##[1:60] (sample_hold || !converter_on || halt_mode))
    else $error("conversions not back to back");
  a_off_idle: assert property (!converter_on [*2] |-> !sample_hold)
    else $error("sampling while off");
  a_restart_sample: assert property ($changed(input_select) &&
    converter_on && !halt_mode |-> ##[0:8] sample_hold)
    else $error("no restart on channel change");
  a_low_pad: assert property ($rose(s_axi_rvalid) &&
    ar_r == 32'h000001C8 |-> s_axi_rdata[31:2] == 30'h0)
    else $error("low result padding not zero");
  a_ctrl_echo: assert property ($rose(s_axi_rvalid) &&
    ar_r == 32'h000001C0 |-> s_axi_rdata[3:0] == input_select &&
    s_axi_rdata[5] == converter_on) else $error("control readback");
  a_unmapped_err: assert property ($rose(s_axi_rvalid) &&
    !(ar_r inside {32'h1C0, 32'h1C4, 32'h1C8}) |->
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read");
  cover property ($fell(converter_on));
  cover property ($rose(s_axi_rvalid) && s_axi_rresp == 2'h2);
  cover property ($changed(input_select) && converter_on);
endmodule
bind adcsq_top adcsq_chk chk_u (.*);
`default_nettype wire

// File: testbench/adcsq_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module adcsq_top_tb;
  logic aclk = 1'h0, aresetn = 1'h0, halt_mode = 1'h0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, rq;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] rr;
  logic [9:0] res, pr;
  wire s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid;
  wire s_axi_rvalid, converter_on, sample_hold, cmp_above;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] input_select;
  wire [9:0] dac_code;
  int checks = 0, mismatches = 0, cyc = 0, lv, pl, t, dv;
  logic [7:0] lo, cw;
  adcsq_top dut_u (.*);
  adcsq_afe afe_u (.*);
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  function int sar(int l);
    return l < 0 ? 0 : (l > 1023 ? 1023 : l);
  endfunction
  task results;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task xfer(input bit w, input logic [31:0] a, input logic [31:0] d);
    logic ta, tw, tr, tb, dn;
    @(posedge aclk);
    if (w) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
    end
    dn = 1'h0;
    for (int n = 0; n < 64 && !dn; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      tb = w ? s_axi_bvalid : s_axi_rvalid;
      rq = s_axi_rdata;
      rr = w ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tr) s_axi_arvalid <= 1'h0;
      if (tb && w) s_axi_bready <= 1'h0;
      if (tb && !w) s_axi_rready <= 1'h0;
      dn = tb;
    end
    if (!dn) begin
      mismatches++;
      results();
    end
  endtask
  task poll;
    int c0;
    c0 = cyc;
    rq = '0;
    for (int n = 0; n < 40 && rq[7] !== 1'h1; n++) xfer(0, 32'h1C0, '0);
    t = cyc - c0;
    `CHK("eoc_set", 1'h1, rq[7])
  endtask
  task get_result;
    xfer(0, 32'h1C8, '0);
    lo = rq[7:0];
    xfer(0, 32'h1C4, '0);
    res = {rq[7:0], lo[1:0]};
    `CHK("low_pad", 6'h0, lo[7:2])
  endtask
  initial begin
    void'($urandom(32'hEA2D));
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      xfer(0, 32'h1C0 + 4 * i, '0);
      `CHK("reset_val", 32'h0, rq)
      `CHK("resp", (i == 3) ? 2'h2 : 2'h0, rr)
    end
    xfer(1, 32'h1C4, 32'hFF);
    `CHK("wr_ro_resp", 2'h0, rr)
    xfer(1, 32'h1CC, 32'h0);
    `CHK("wr_bad_resp", 2'h2, rr)
    xfer(0, 32'h1C4, '0);
    `CHK("ro_high", 32'h0, rq)
    $display("test registers done");
    for (int k = 0; k < 16; k++) begin
      lv = (k == 0) ? 2000 : (k == 1) ? -5 : 60 * k + $urandom % 40;
      afe_u.lvl[k] = lv;
      dv = k[0] ? 2 : 4;
      cw = {2'h0 + k[0], 2'h2, k[3:0]};
      xfer(1, 32'h1C0, {24'h0, cw});
      xfer(0, 32'h1C0, '0);
      `CHK("ctrl", cw, rq[7:0])
      poll();
      `CHK("conv_time", 1'h1, t > 12 * dv - 10 && t < 12 * dv + 8)
      get_result();
      `CHK("result", sar(lv), res)
      xfer(0, 32'h1C0, '0);
      `CHK("eoc_rd", 1'h0, rq[7])
      if (k > 0) `CHK("mono", 1'h1, lv >= pl ? res >= pr : res <= pr)
      pl = lv;
      pr = res;
    end
    $display("test channels done");
    afe_u.lvl[15] = 7;
    poll();
    xfer(1, 32'h1C0, 32'h6F);
    xfer(0, 32'h1C0, '0);
    `CHK("eoc_wr", 8'h6F, rq[7:0])
    poll();
    get_result();
    `CHK("overwrite", 10'h007, res)
    $display("test overwrite done");
    @(posedge aclk);
    halt_mode <= 1'h1;
    xfer(1, 32'h1C0, 32'h6F);
    repeat (80) @(posedge aclk);
    xfer(0, 32'h1C0, '0);
    `CHK("halt", 8'h6F, rq[7:0])
    halt_mode <= 1'h0;
    poll();
    xfer(1, 32'h1C0, 32'h4F);
    repeat (80) @(posedge aclk);
    xfer(0, 32'h1C0, '0);
    `CHK("off", 8'h4F, rq[7:0])
    $display("test power done");
    results();
  end
endmodule
`default_nettype wire
